// [design/dcb_pkg.sv]
/*
 dcb_pkg: constants, register map and sequencer states of the dc brake and
 frequency limiter block.
 Assumes a 200 MHz clock; frequencies in 0.01 Hz, times in 0.1 s units.
*/
package dcb_pkg;
   localparam int FREQ_W = 16;
   localparam int TIME_W = 10;
   localparam int TORQ_W = 7;
   localparam int PULSE_W = 8;
   localparam int NUM_JUMPS = 3;

   // timing: one time unit is 0.1 s
   localparam int CLK_PERIOD_PS = 5000;
   localparam longint TIME_UNIT_PS = 64'd100_000_000_000;
   localparam int TICK_CYCLES = int'(TIME_UNIT_PS / CLK_PERIOD_PS);

   // setting limits (frequency 0.01 Hz, time 0.1 s, pulse 0.1 kHz)
   localparam logic [FREQ_W-1:0] ACT_FREQ_MAX = 16'h1770;      // 60 Hz
   localparam logic [FREQ_W-1:0] OP_FREQ_MAX = 16'h9C40;       // 400 Hz
   localparam logic [FREQ_W-1:0] JUMP_W_MAX = 16'h03E8;        // 10 Hz
   localparam logic [TIME_W-1:0] COAST_MAX = 10'h032;          // 5 s
   localparam logic [TIME_W-1:0] DUR_MAX = 10'h258;            // 60 s
   localparam logic [TORQ_W-1:0] TORQ_MAX = 7'h64;             // 100 %
   localparam logic [PULSE_W-1:0] PULSE_MIN = 8'h05;           // 0.5 kHz
   localparam logic [PULSE_W-1:0] PULSE_MAX_SMALL = 8'h78;     // 12 kHz
   localparam logic [PULSE_W-1:0] PULSE_MAX_LARGE = 8'h64;     // 10 kHz

   // reset values
   localparam logic RST_AUTO_EN = 1'b0;
   localparam logic RST_BEHAVIOUR = 1'b1;
   localparam logic [FREQ_W-1:0] RST_ACT_FREQ = 16'h0032;      // 0.50 Hz
   localparam logic [PULSE_W-1:0] RST_PULSE = 8'h1E;           // 3.0 kHz
   localparam logic [FREQ_W-1:0] RST_JUMP_W = 16'h0032;        // 0.5 Hz
   localparam logic [FREQ_W-1:0] RST_START_FREQ = 16'h0032;
   localparam logic [FREQ_W-1:0] RST_END_FREQ = 16'h1388;
   localparam logic [FREQ_W-1:0] RST_SW_FREQ = 16'h0032;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ACT_FREQ = 8'h04;
   localparam logic [7:0] OFS_COAST = 8'h08;
   localparam logic [7:0] OFS_DEC_TORQ = 8'h0C;
   localparam logic [7:0] OFS_DEC_DUR = 8'h10;
   localparam logic [7:0] OFS_ACC_TORQ = 8'h14;
   localparam logic [7:0] OFS_ACC_DUR = 8'h18;
   localparam logic [7:0] OFS_PULSE = 8'h1C;
   localparam logic [7:0] OFS_MAX_OP = 8'h20;
   localparam logic [7:0] OFS_MIN_OP = 8'h24;
   localparam logic [7:0] OFS_START_F = 8'h28;
   localparam logic [7:0] OFS_END_F = 8'h2C;
   localparam logic [7:0] OFS_JUMP_BASE = 8'h30;               // centre, width pairs
   localparam logic [7:0] OFS_SW_FREQ = 8'h48;
   localparam logic [7:0] OFS_STATUS = 8'h4C;

   // control register fields
   localparam int CTRL_AUTO_BIT = 0;
   localparam int CTRL_BEHAV_BIT = 1;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PRE_BRAKE,
      ST_RUN,
      ST_STOPPING,
      ST_COAST,
      ST_BRAKE,
      ST_DONE
   } dcb_state_e;
endpackage

// [design/dcb_freq_limiter.sv]
/*
 dcb_freq_limiter: clamps the commanded frequency to the operating window and
 keeps it out of three jump bands while rampActive is low; registered output.
 Assumes all inputs come from the clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dcb_freq_limiter
   import dcb_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic runEnable,
   input wire logic startPulse,
   input wire logic rampActive,
   input wire logic [dcb_pkg::FREQ_W-1:0] setpointFreq,
   input wire logic [dcb_pkg::FREQ_W-1:0] startingFreq,
   input wire logic [dcb_pkg::FREQ_W-1:0] endFreq,
   input wire logic [dcb_pkg::FREQ_W-1:0] maxOperatingFreq,
   input wire logic [dcb_pkg::FREQ_W-1:0] minOperatingFreq,
   input wire logic [dcb_pkg::NUM_JUMPS-1:0][dcb_pkg::FREQ_W-1:0] jumpCentre,
   input wire logic [dcb_pkg::NUM_JUMPS-1:0][dcb_pkg::FREQ_W-1:0] jumpWidth,
   output logic [dcb_pkg::FREQ_W-1:0] limitedFreq
);
   typedef struct packed {
      logic [FREQ_W-1:0] outFreq;
   } dcb_lim_s;

   dcb_lim_s r;
   dcb_lim_s n;

   always_comb
   begin
      logic [FREQ_W-1:0] f;
      logic [FREQ_W-1:0] lo;
      logic [FREQ_W-1:0] hi;
      logic [FREQ_W:0] edgeLo;
      logic [FREQ_W:0] edgeHi;
      edgeLo = '0;
      edgeHi = '0;
      f = startPulse ? minOperatingFreq : setpointFreq;
      lo = (minOperatingFreq > startingFreq) ? minOperatingFreq : startingFreq;
      hi = endFreq;
      if ((maxOperatingFreq != '0) && (maxOperatingFreq < hi))
      begin
         hi = maxOperatingFreq;
      end
      if (f > hi)
      begin
         f = hi;
      end
      if (f < lo)
      begin
         f = lo;
      end
      // the band may be crossed while ramping, never held inside
      for (int i = 0; i < NUM_JUMPS; i++)
      begin
         edgeLo = {1'b0, jumpCentre[i]} - {2'b00, jumpWidth[i][FREQ_W-1:1]};
         edgeHi = {1'b0, jumpCentre[i]} + {2'b00, jumpWidth[i][FREQ_W-1:1]};
         if (edgeLo[FREQ_W])
         begin
            edgeLo = '0;
         end
         if (!rampActive && (jumpWidth[i] != '0) && ({1'b0, f} > edgeLo) && ({1'b0, f} < edgeHi))
         begin
            if (({1'b0, f} - edgeLo) <= (edgeHi - {1'b0, f}))
            begin
               f = edgeLo[FREQ_W-1:0];
            end
            else if (edgeHi > {1'b0, hi})
            begin
               f = edgeLo[FREQ_W-1:0];
            end
            else
            begin
               f = edgeHi[FREQ_W-1:0];
            end
         end
      end
      n.outFreq = runEnable ? f : '0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r <= '0;
      end
      else
      begin
         r <= n;
      end
   end

   assign limitedFreq = r.outFreq;
endmodule
`default_nettype wire

// [design/dcb_brake_ctrl.sv]
/*
 dcb_brake_ctrl: dc injection brake sequencer with APB register file, driving
 the power stage and limiting the commanded output frequency.
 Assumes run command and brake request come from pins (synchronised here);
 actual and setpoint frequency come from logic on clk.
*/
// Notes on behaviour
// - brake starts on stop with auto braking, or on brake request input
// - auto brake enable: 0 off, 1 on; off after reset
// - auto braking begins when actual frequency drops below activation frequency
// - motor coasts for the wait time, 0 to 5 s, before braking
// - deceleration brake torque setting 0 to 100 percent
// - deceleration braking lasts the configured duration, 0 to 60 s
// - behaviour 0: input edge starts braking, duration expiry ends it
// - behaviour 1 (default): brake while input active, stop on release
// - braking before acceleration uses its own torque, 0 to 100 percent
// - pre-acceleration braking lasts its own duration, 0 to 60 s
// - brake pulse frequency 0.5 to 12 or 10 kHz, default 3.0 kHz
// - brake pulse frequency replaces switching frequency only while braking
// - braking drives pulsed dc, no rotating output
// - optional min and max limits narrow the start-to-end frequency range
// - start command immediately outputs minimum operating frequency
// - maximum operating frequency 0 to 400 Hz, zero disables it
// - three jump bands: centre 0 to 400 Hz, width 0 to 10 Hz
`timescale 1ns/1ps
`default_nettype none
module dcb_brake_ctrl
   import dcb_pkg::*;
#(
   parameter int TICK_CYCLES_P = dcb_pkg::TICK_CYCLES,
   parameter logic [dcb_pkg::PULSE_W-1:0] PULSE_MAX_P = dcb_pkg::PULSE_MAX_SMALL
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic runCommand,
   input wire logic brakeRequestInput,
   input wire logic rampActive,
   input wire logic [dcb_pkg::FREQ_W-1:0] actualFreq,
   input wire logic [dcb_pkg::FREQ_W-1:0] setpointFreq,
   output logic dcInjectBrake,
   output logic [dcb_pkg::TORQ_W-1:0] brakeTorque,
   output logic [dcb_pkg::PULSE_W-1:0] switchingFreq,
   output logic outputEnable,
   output logic [dcb_pkg::FREQ_W-1:0] limitedFreq
);
   import dcb_pkg::*;

   typedef struct packed {
      dcb_state_e state;
      logic [1:0] runSync;
      logic [1:0] brakeSync;
      logic runPrev;
      logic brakePrev;
      logic fromInput;
      logic startPulse;
      logic [31:0] presc;
      logic [TIME_W-1:0] coastTmr;
      logic [TIME_W-1:0] brakeTmr;
      logic [TIME_W-1:0] preTmr;
      logic autoEn;
      logic behaviour;
      logic [FREQ_W-1:0] actFreq;
      logic [TIME_W-1:0] coastWait;
      logic [TORQ_W-1:0] decTorque;
      logic [TIME_W-1:0] decDur;
      logic [TORQ_W-1:0] accTorque;
      logic [TIME_W-1:0] accDur;
      logic [PULSE_W-1:0] pulseFreq;
      logic [FREQ_W-1:0] maxOp;
      logic [FREQ_W-1:0] minOp;
      logic [FREQ_W-1:0] startF;
      logic [FREQ_W-1:0] endF;
      logic [PULSE_W-1:0] swFreq;
      logic [NUM_JUMPS-1:0][FREQ_W-1:0] jumpC;
      logic [NUM_JUMPS-1:0][FREQ_W-1:0] jumpW;
      logic [31:0] rdata;
   } dcb_regs_s;

   localparam dcb_regs_s RESET_VAL = '{
      state: ST_IDLE,
      behaviour: RST_BEHAVIOUR,
      autoEn: RST_AUTO_EN,
      actFreq: RST_ACT_FREQ,
      pulseFreq: RST_PULSE,
      startF: RST_START_FREQ,
      endF: RST_END_FREQ,
      swFreq: RST_SW_FREQ[PULSE_W-1:0],
      jumpW: {NUM_JUMPS{RST_JUMP_W}},
      default: '0
   };

   dcb_regs_s r;
   dcb_regs_s n;

   // writes beyond range saturate rather than wrap, except the switching frequency, which keeps only its low 8 bits
   function automatic logic [FREQ_W-1:0] clampVal(input logic [31:0] v, input logic [FREQ_W-1:0] maxV);
      return (v > {16'h0000, maxV}) ? maxV : v[FREQ_W-1:0];
   endfunction

   function automatic logic [TIME_W-1:0] clampTime(input logic [31:0] v, input logic [TIME_W-1:0] maxV);
      return (v > {22'h00_0000, maxV}) ? maxV : v[TIME_W-1:0];
   endfunction

   logic setup;
   logic access;
   logic mapped;
   logic tick;
   logic runLvl;
   logic brakeLvl;
   logic runRise;
   logic brakeRise;
   logic [7:0] jumpOfs;

   assign setup = psel && !penable;
   assign access = psel && penable;
   assign runLvl = r.runSync[1];
   assign brakeLvl = r.brakeSync[1];
   assign runRise = r.runSync[1] && !r.runPrev;
   assign brakeRise = r.brakeSync[1] && !r.brakePrev;
   assign tick = (r.presc == 32'(TICK_CYCLES_P - 1));
   assign jumpOfs = paddr - OFS_JUMP_BASE;
   assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_STATUS);

   always_comb
   begin
      n = r;
      n.runSync = {r.runSync[0], runCommand};
      n.brakeSync = {r.brakeSync[0], brakeRequestInput};
      n.runPrev = r.runSync[1];
      n.brakePrev = r.brakeSync[1];
      n.startPulse = 1'b0;
      n.presc = tick ? '0 : r.presc + 32'h0000_0001;

      case (r.state)
         ST_IDLE:
         begin
            if (brakeRise)
            begin
               n.state = ST_COAST;
               n.fromInput = 1'b1;
               n.coastTmr = r.coastWait;
            end
            else if (runRise)
            begin
               if (r.accDur != '0)
               begin
                  n.state = ST_PRE_BRAKE;
                  n.preTmr = r.accDur;
               end
               else
               begin
                  n.state = ST_RUN;
                  n.startPulse = 1'b1;
               end
            end
         end
         ST_PRE_BRAKE:
         begin
            if (!runLvl)
            begin
               n.state = ST_IDLE;
            end
            else if (tick)
            begin
               if (r.preTmr <= 10'h001)
               begin
                  n.state = ST_RUN;
                  n.startPulse = 1'b1;
               end
               else
               begin
                  n.preTmr = r.preTmr - 10'h001;
               end
            end
         end
         ST_RUN:
         begin
            if (brakeRise)
            begin
               n.state = ST_COAST;
               n.fromInput = 1'b1;
               n.coastTmr = r.coastWait;
            end
            else if (!runLvl)
            begin
               n.state = r.autoEn ? ST_STOPPING : ST_IDLE;
            end
         end
         ST_STOPPING:
         begin
            if (brakeRise)
            begin
               n.state = ST_COAST;
               n.fromInput = 1'b1;
               n.coastTmr = r.coastWait;
            end
            else if (runRise)
            begin
               n.state = ST_RUN;
               n.startPulse = 1'b1;
            end
            else if (actualFreq < r.actFreq)
            begin
               n.state = ST_COAST;
               n.fromInput = 1'b0;
               n.coastTmr = r.coastWait;
            end
         end
         ST_COAST:
         begin
            if (r.fromInput && r.behaviour && !brakeLvl)
            begin
               n.state = ST_DONE;
            end
            else if (r.coastTmr == '0)
            begin
               n.state = ST_BRAKE;
               n.brakeTmr = r.decDur;
            end
            else if (tick)
            begin
               n.coastTmr = r.coastTmr - 10'h001;
            end
         end
         ST_BRAKE:
         begin
            if (r.fromInput && r.behaviour)
            begin
               if (!brakeLvl)
               begin
                  n.state = ST_DONE;
               end
            end
            else if (r.brakeTmr == '0)
            begin
               n.state = ST_DONE;
            end
            else if (tick)
            begin
               n.brakeTmr = r.brakeTmr - 10'h001;
            end
         end
         ST_DONE:
         begin
            n.state = ST_IDLE;
            n.fromInput = 1'b0;
         end
         default:
         begin
            n.state = ST_IDLE;
         end
      endcase

      // timers start on a whole unit from entry into a timed state
      if (n.state != r.state)
      begin
         n.presc = '0;
      end

      if (setup)
      begin
         n.rdata = '0;
         case (paddr)
            OFS_CTRL: n.rdata = {30'h0000_0000, r.behaviour, r.autoEn};
            OFS_ACT_FREQ: n.rdata = {16'h0000, r.actFreq};
            OFS_COAST: n.rdata = {22'h00_0000, r.coastWait};
            OFS_DEC_TORQ: n.rdata = {25'h000_0000, r.decTorque};
            OFS_DEC_DUR: n.rdata = {22'h00_0000, r.decDur};
            OFS_ACC_TORQ: n.rdata = {25'h000_0000, r.accTorque};
            OFS_ACC_DUR: n.rdata = {22'h00_0000, r.accDur};
            OFS_PULSE: n.rdata = {24'h00_0000, r.pulseFreq};
            OFS_MAX_OP: n.rdata = {16'h0000, r.maxOp};
            OFS_MIN_OP: n.rdata = {16'h0000, r.minOp};
            OFS_START_F: n.rdata = {16'h0000, r.startF};
            OFS_END_F: n.rdata = {16'h0000, r.endF};
            OFS_SW_FREQ: n.rdata = {24'h00_0000, r.swFreq};
            OFS_STATUS: n.rdata = {27'h000_0000, dcInjectBrake, outputEnable, r.state};
            default:
            begin
               if (mapped && (jumpOfs < 8'h18))
               begin
                  n.rdata = {16'h0000, jumpOfs[2] ? r.jumpW[jumpOfs[4:3]] : r.jumpC[jumpOfs[4:3]]};
               end
            end
         endcase
      end

      if (access && pwrite && mapped)
      begin
         case (paddr)
            OFS_CTRL:
            begin
               n.autoEn = pwdata[CTRL_AUTO_BIT];
               n.behaviour = pwdata[CTRL_BEHAV_BIT];
            end
            OFS_ACT_FREQ: n.actFreq = clampVal(pwdata, ACT_FREQ_MAX);
            OFS_COAST: n.coastWait = clampTime(pwdata, COAST_MAX);
            OFS_DEC_TORQ: n.decTorque = TORQ_W'(clampVal(pwdata, 16'(TORQ_MAX)));
            OFS_DEC_DUR: n.decDur = clampTime(pwdata, DUR_MAX);
            OFS_ACC_TORQ: n.accTorque = TORQ_W'(clampVal(pwdata, 16'(TORQ_MAX)));
            OFS_ACC_DUR: n.accDur = clampTime(pwdata, DUR_MAX);
            OFS_PULSE:
            begin
               n.pulseFreq = PULSE_W'(clampVal(pwdata, 16'(PULSE_MAX_P)));
               if (n.pulseFreq < PULSE_MIN)
               begin
                  n.pulseFreq = PULSE_MIN;
               end
            end
            OFS_MAX_OP: n.maxOp = clampVal(pwdata, OP_FREQ_MAX);
            OFS_MIN_OP: n.minOp = clampVal(pwdata, OP_FREQ_MAX);
            OFS_START_F: n.startF = clampVal(pwdata, OP_FREQ_MAX);
            OFS_END_F: n.endF = clampVal(pwdata, OP_FREQ_MAX);
            OFS_SW_FREQ: n.swFreq = pwdata[PULSE_W-1:0];
            default:
            begin
               if (jumpOfs < 8'h18)
               begin
                  if (jumpOfs[2])
                  begin
                     n.jumpW[jumpOfs[4:3]] = clampVal(pwdata, JUMP_W_MAX);
                  end
                  else
                  begin
                     n.jumpC[jumpOfs[4:3]] = clampVal(pwdata, OP_FREQ_MAX);
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r <= RESET_VAL;
      end
      else
      begin
         r <= n;
      end
   end

   assign prdata = r.rdata;
   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   // torque is applied only in the braking states; no derating enforced here
   assign dcInjectBrake = (r.state == ST_BRAKE) || (r.state == ST_PRE_BRAKE);
   assign brakeTorque = (r.state == ST_BRAKE) ? r.decTorque :
                        (r.state == ST_PRE_BRAKE) ? r.accTorque : '0;
   assign switchingFreq = dcInjectBrake ? r.pulseFreq : r.swFreq;
   assign outputEnable = (r.state == ST_RUN) || (r.state == ST_STOPPING);

   dcb_freq_limiter u_limiter (
      .clk(clk),
      .rst_n(rst_n),
      .runEnable(outputEnable),
      .startPulse(r.startPulse),
      .rampActive(rampActive),
      .setpointFreq(setpointFreq),
      .startingFreq(r.startF),
      .endFreq(r.endF),
      .maxOperatingFreq(r.maxOp),
      .minOperatingFreq(r.minOp),
      .jumpCentre(r.jumpC),
      .jumpWidth(r.jumpW),
      .limitedFreq(limitedFreq)
   );
endmodule
`default_nettype wire

// [testbench/dcb_brake_monitor.sv]
/*
 dcb_brake_monitor: concurrent checks on the brake controller outputs.
 Assumes binding into dcb_brake_ctrl; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module dcb_brake_monitor
   import dcb_pkg::*;
#(
   parameter int TICK_CYCLES_P = dcb_pkg::TICK_CYCLES,
   parameter logic [dcb_pkg::PULSE_W-1:0] PULSE_MAX_P = dcb_pkg::PULSE_MAX_SMALL
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic brakeRequestInput,
   input wire logic dcInjectBrake,
   input wire logic [dcb_pkg::TORQ_W-1:0] brakeTorque,
   input wire logic [dcb_pkg::PULSE_W-1:0] switchingFreq,
   input wire logic outputEnable,
   input wire logic [dcb_pkg::FREQ_W-1:0] limitedFreq
);
   import dcb_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_torque_idle: assert property (!dcInjectBrake |-> brakeTorque == '0)
      else $error("torque present without braking");
   a_pulse_range: assert property (dcInjectBrake |-> switchingFreq inside {[PULSE_MIN:PULSE_MAX_P]})
      else $error("brake pulse frequency out of range");
   a_no_rotate: assert property (dcInjectBrake |-> !outputEnable)
      else $error("rotating output while braking");
   a_freq_off: assert property (!outputEnable |=> limitedFreq == '0)
      else $error("frequency output while disabled");
   a_max_limit: assert property (limitedFreq <= OP_FREQ_MAX)
      else $error("frequency above operating maximum");
   a_pin_latency: assert property ($rose(brakeRequestInput) && outputEnable |-> ##[2:4] !outputEnable)
      else $error("brake request did not stop rotation");
   a_torque_range: assert property (brakeTorque <= TORQ_MAX)
      else $error("torque above full scale");
   a_coast_first: assert property ($rose(dcInjectBrake) |-> !$past(outputEnable))
      else $error("braking began straight from rotation");
   a_brake_end: assert property ($fell(dcInjectBrake) && !outputEnable |=> !outputEnable)
      else $error("rotation resumed straight from braking");
endmodule

bind dcb_brake_ctrl dcb_brake_monitor #(.TICK_CYCLES_P(TICK_CYCLES_P), .PULSE_MAX_P(PULSE_MAX_P)) mon_inst (
   .clk(clk),
   .rst_n(rst_n),
   .brakeRequestInput(brakeRequestInput),
   .dcInjectBrake(dcInjectBrake),
   .brakeTorque(brakeTorque),
   .switchingFreq(switchingFreq),
   .outputEnable(outputEnable),
   .limitedFreq(limitedFreq)
);
`default_nettype wire

// [testbench/dcb_power_stage.sv]
/*
 dcb_power_stage: power stage stand-in; counts cycles of pulsed dc output.
 Assumes the controller's brake and enable outputs on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module dcb_power_stage (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic dcInjectBrake,
   input wire logic outputEnable,
   output logic [15:0] brakeCycles
);
   // pulsed dc only counts when the rotating bridge is off
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         brakeCycles <= 16'h0000;
      else if (dcInjectBrake && !outputEnable)
         brakeCycles <= brakeCycles + 16'h0001;
endmodule
`default_nettype wire

// [testbench/tb.sv]
/*
 tb: register, braking and frequency limit tests of dcb_brake_ctrl.
 Assumes the power stage model and the bound monitor.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   import dcb_pkg::*;
   localparam int TK = 4;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
   logic runCommand, brakeRequestInput, rampActive, dcInjectBrake, outputEnable;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [15:0] actualFreq, setpointFreq, limitedFreq, brakeCycles, b0, c;
   logic [6:0] brakeTorque;
   logic [7:0] switchingFreq;
   int fails = 0, n_tests = 0, n;
   logic [7:0] ra [7] = '{OFS_CTRL, OFS_ACT_FREQ, OFS_PULSE, 8'h34, OFS_END_F, OFS_SW_FREQ, OFS_STATUS};
   logic [31:0] rv [7] = '{32'h0000_0002, 32'h0000_0032, 32'h0000_001E, 32'h0000_0032, 32'h0000_1388,
      32'h0000_0032, 32'h0000_0000};
   logic [7:0] sa [6] = '{OFS_ACT_FREQ, OFS_PULSE, OFS_PULSE, OFS_COAST, OFS_DEC_TORQ, OFS_MAX_OP};
   logic [31:0] sw [6] = '{32'h0000_FFFF, 32'h0000_00FF, 32'h0000_0000, 32'h0000_FFFF, 32'h0000_00FF, 32'h0000_FFFF};
   logic [31:0] sx [6] = '{32'h0000_1770, 32'h0000_0078, 32'h0000_0005, 32'h0000_0032, 32'h0000_0064, 32'h0000_9C40};

   dcb_brake_ctrl #(.TICK_CYCLES_P(TK), .PULSE_MAX_P(PULSE_MAX_SMALL)) dcb_brake_ctrl_inst (.clk(clk),
      .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .runCommand(runCommand),
      .brakeRequestInput(brakeRequestInput), .rampActive(rampActive), .actualFreq(actualFreq),
      .setpointFreq(setpointFreq), .dcInjectBrake(dcInjectBrake), .brakeTorque(brakeTorque),
      .switchingFreq(switchingFreq), .outputEnable(outputEnable), .limitedFreq(limitedFreq));
   dcb_power_stage dcb_power_stage_inst (.clk(clk), .rst_n(rst_n), .dcInjectBrake(dcInjectBrake),
      .outputEnable(outputEnable), .brakeCycles(brakeCycles));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      n_tests++;
      if (s !== x)
      begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk(r, x);
   endtask

   // wait for the brake output level, bounded
   task automatic wt(input logic v);
      n = 0;
      while (dcInjectBrake !== v && n < 999)
      begin
         @(posedge clk);
         n++;
      end
      chk(32'(n < 999), 32'h1);
   endtask

   task automatic lim(input logic [15:0] sp, input logic [15:0] x);
      @(posedge clk);
      setpointFreq <= sp;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(32'(limitedFreq), 32'(x));
      @(posedge clk);
   endtask

   task automatic startrun;
      @(posedge clk);
      runCommand <= 1'b1;
      wt(1'b1);
      wt(1'b0);
      repeat (4) @(posedge clk);
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      repeat (30000) @(posedge clk);
      fails++;
      wrap_up;
   end

   initial
   begin
      {rst_n, psel, penable, pwrite, runCommand, brakeRequestInput, rampActive} = '0;
      paddr = '0;
      pwdata = '0;
      actualFreq = '0;
      setpointFreq = '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 7; i++)
         rc(ra[i], rv[i]);
      apb(1'b0, 8'h50, 32'h0000_0000);
      chk(32'(e), 32'h1);
      chk(r, 32'h0000_0000);
      for (int i = 0; i < 6; i++)
      begin
         wr(sa[i], sw[i]);
         rc(sa[i], sx[i]);
      end
      wr(OFS_MAX_OP, 32'h0000_0000);
      wr(OFS_COAST, 32'h0000_0002);
      wr(OFS_DEC_TORQ, 32'h0000_0028);
      wr(OFS_PULSE, 32'h0000_0040);
      wr(OFS_DEC_DUR, 32'h0000_0001);
      // held input: brake must outlast the duration
      brakeRequestInput <= 1'b1;
      wt(1'b1);
      chk(32'(n >= 2 * TK && n <= 2 * TK + 6), 32'h1);
      @(negedge clk);
      chk(32'(brakeTorque), 32'h0000_0028);
      chk(32'(switchingFreq), 32'h0000_0040);
      repeat (6 * TK) @(posedge clk);
      chk(32'(dcInjectBrake), 32'h1);
      brakeRequestInput <= 1'b0;
      wt(1'b0);
      chk(32'(n <= 6), 32'h1);
      repeat (3) @(posedge clk);
      rc(OFS_STATUS, 32'h0000_0000);
      chk(32'(switchingFreq), 32'h0000_0032);
      wr(OFS_CTRL, 32'h0000_0000);
      wr(OFS_DEC_DUR, 32'h0000_0003);
      wr(OFS_COAST, 32'h0000_0000);
      b0 = brakeCycles;
      brakeRequestInput <= 1'b1;
      repeat (4) @(posedge clk);
      brakeRequestInput <= 1'b0;
      wt(1'b1);
      wt(1'b0);
      c = brakeCycles - b0;
      chk(32'(c >= 3 * TK && c <= 3 * TK + 2), 32'h1);
      wr(OFS_ACC_TORQ, 32'h0000_0019);
      wr(OFS_ACC_DUR, 32'h0000_0002);
      wr(OFS_MIN_OP, 32'h0000_03E8);
      setpointFreq <= 16'h01F4;
      b0 = brakeCycles;
      runCommand <= 1'b1;
      wt(1'b1);
      @(negedge clk);
      chk(32'(brakeTorque), 32'h0000_0019);
      wt(1'b0);
      c = brakeCycles - b0;
      chk(32'(c >= 2 * TK && c <= 2 * TK + 2), 32'h1);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(32'(outputEnable), 32'h1);
      chk(32'(limitedFreq), 32'h0000_03E8);
      lim(16'h1770, 16'h1388);
      wr(OFS_MAX_OP, 32'h0000_0BB8);
      lim(16'h1770, 16'h0BB8);
      wr(OFS_MAX_OP, 32'h0000_0000);
      lim(16'h1770, 16'h1388);
      for (int j = 0; j < 3; j++)
      begin
         c = 16'h07D0 + 16'(j * 1000);
         wr(OFS_JUMP_BASE + 8'(8 * j), 32'(c));
         wr(OFS_JUMP_BASE + 8'(8 * j + 4), 32'h0000_00C8);
         lim(c + 16'h0032, c + 16'h0064);
         lim(c - 16'h0032, c - 16'h0064);
         rampActive <= 1'b1;
         lim(c + 16'h0032, c + 16'h0032);
         rampActive <= 1'b0;
      end
      // auto stop waits for the activation frequency
      wr(OFS_CTRL, 32'h0000_0001);
      wr(OFS_ACT_FREQ, 32'h0000_03E8);
      wr(OFS_DEC_DUR, 32'h0000_0002);
      actualFreq <= 16'h0BB8;
      runCommand <= 1'b0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk(32'(outputEnable), 32'h1);
      chk(32'(dcInjectBrake), 32'h0);
      @(posedge clk);
      actualFreq <= 16'h01F4;
      wt(1'b1);
      chk(32'(n <= 8), 32'h1);
      @(negedge clk);
      chk(32'(brakeTorque), 32'h0000_0028);
      wt(1'b0);
      startrun;
      wr(OFS_CTRL, 32'h0000_0000);
      b0 = brakeCycles;
      runCommand <= 1'b0;
      repeat (12) @(posedge clk);
      chk(32'(brakeCycles - b0), 32'h0);
      chk(32'(outputEnable), 32'h0);
      startrun;
      brakeRequestInput <= 1'b1;
      wt(1'b1);
      chk(32'(n <= 6), 32'h1);
      brakeRequestInput <= 1'b0;
      wt(1'b0);
      wrap_up;
   end
endmodule
`default_nettype wire
